// ---- include/asr_pkg.sv ----
// Package with register map, status codes and timing of the AL status reporter
// Operation
// [R1] Corrupt stored control data reports 0001, saved
// [R2] Illegal transition request reports 0011, not saved
// [R3] Unknown target state reports 0012, not saved
// [R4] Bootstrap request reports 0013; master avoids it
// [R5] Power-up identity mismatch reports 0014, saved
// [R6] Bad mailbox channel setting reports 0016
// [R7] Process-data watchdog expiry reports 001B
// [R8] Inconsistent receive channel setting reports 001D
// [R9] Inconsistent transmit channel setting reports 001E
// [R10] Invalid watchdog setting reports 001F, not taken
// [R11] Device asks for Init with 0021
// [R12] Transmit mapping entry out of range reports 0024
// [R13] Receive mapping entry out of range reports 0025
// [R14] Unsupported event mode reports 0028
// [R15] Non triple buffer mode reports 0029
// [R16] SYNC0 stops in Operational reports 002C
// [R17] No SYNC0 since clock mode entry reports 002D
// [R18] Invalid clock mode setting reports 0030
// [R19] Code held until next state request
// [R20] First fault wins until cleared
package asr_pkg;

  // Register byte offsets
  localparam logic [7:0] ASR_OFF_STATUS = 8'h00;  // Code and error flag
  localparam logic [7:0] ASR_OFF_STATE  = 8'h04;  // State request
  localparam logic [7:0] ASR_OFF_MBX    = 8'h08;  // Mailbox channel length
  localparam logic [7:0] ASR_OFF_RXSM   = 8'h0C;  // Receive channel setting
  localparam logic [7:0] ASR_OFF_TXSM   = 8'h10;  // Transmit channel setting
  localparam logic [7:0] ASR_OFF_SYNC   = 8'h14;  // Event and clock modes
  localparam logic [7:0] ASR_OFF_WDT    = 8'h18;  // Watchdog time in us
  localparam logic [7:0] ASR_OFF_TXMAP  = 8'h1C;  // Transmit mapping entry
  localparam logic [7:0] ASR_OFF_RXMAP  = 8'h20;  // Receive mapping entry
  localparam logic [7:0] ASR_OFF_CTRL   = 8'h24;  // Bit 0 asks for Init
  localparam logic [7:0] ASR_OFF_HIST   = 8'h28;  // Saved count and last code

  // Field positions
  localparam int ASR_LEN_HI  = 15;  // Length field top bit
  localparam int ASR_BUF_LO  = 16;  // Buffer mode field low bit
  localparam int ASR_ERR_BIT = 16;  // Error flag in status word

  // State codes
  localparam logic [3:0] ASR_ST_INIT = 4'h1;
  localparam logic [3:0] ASR_ST_PREOP = 4'h2;
  localparam logic [3:0] ASR_ST_BOOT = 4'h3;
  localparam logic [3:0] ASR_ST_SAFEOP = 4'h4;
  localparam logic [3:0] ASR_ST_OP = 4'h8;

  // Mode encodings
  localparam logic [1:0] ASR_BUF_TRIPLE = 2'h0;  // Only allowed buffer mode
  localparam logic [1:0] ASR_EVM_MAX    = 2'h1;  // Highest event mode served
  localparam logic [2:0] ASR_DC_OFF     = 3'h0;  // Clock sync off
  localparam logic [2:0] ASR_DC_MAX     = 3'h1;  // Highest clock mode served

  // Mapping entry limits
  localparam logic [15:0] ASR_TX_IDX_LO = 16'h6000;
  localparam logic [15:0] ASR_TX_IDX_HI = 16'h6FFF;
  localparam logic [15:0] ASR_RX_IDX_LO = 16'h7000;
  localparam logic [15:0] ASR_RX_IDX_HI = 16'h7FFF;
  localparam logic [7:0]  ASR_SUB_MAX   = 8'h40;
  localparam logic [7:0]  ASR_SIZE_MAX  = 8'h40;

  // Reset values
  localparam logic [15:0] ASR_WDT_RST = 16'h0064;  // Watchdog time after reset
  localparam logic [15:0] ASR_MBX_RST = 16'h0080;  // Mailbox length after reset

  // Timing: one microsecond tick
  localparam int ASR_CLK_NS   = 10;
  localparam int ASR_TICK_NS  = 1000;
  localparam int ASR_TICK_CYC = (ASR_TICK_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;

  // Fault slots, lowest index wins
  localparam int ASR_NE = 18;
  localparam int EV_NVM = 0;
  localparam int EV_ILLEGAL = 1;
  localparam int EV_UNKNOWN = 2;
  localparam int EV_BOOT = 3;
  localparam int EV_ID = 4;
  localparam int EV_MBX = 5;
  localparam int EV_WDT = 6;
  localparam int EV_RXSM = 7;
  localparam int EV_TXSM = 8;
  localparam int EV_WDTCFG = 9;
  localparam int EV_INIT = 10;
  localparam int EV_TXMAP = 11;
  localparam int EV_RXMAP = 12;
  localparam int EV_EVMODE = 13;
  localparam int EV_BUF = 14;
  localparam int EV_SYNCLOST = 15;
  localparam int EV_NOSYNC = 16;
  localparam int EV_DCCFG = 17;

  // Status code of each slot
  localparam logic [15:0] ASR_CODE [ASR_NE] = '{
    16'h0001, 16'h0011, 16'h0012, 16'h0013, 16'h0014, 16'h0016,
    16'h001B, 16'h001D, 16'h001E, 16'h001F, 16'h0021, 16'h0024,
    16'h0025, 16'h0028, 16'h0029, 16'h002C, 16'h002D, 16'h0030};

endpackage

// ---- src/asr_al_status.sv ----
// AL status code reporter with APB register slave
`timescale 1ns/100ps
module asr_al_status #(
  parameter int          SYNC_TO_US  = 1000,          // SYNC0 silence limit in us
  parameter int          MBX_MIN_LEN = 8,             // Least mailbox length
  parameter logic [31:0] ID_EXPECTED = 32'h1234_5678  // Arbitrary identity value
) (
  input  wire logic        i_clk,       // System clock
  input  wire logic        i_rst,       // Synchronous reset
  input  wire logic        i_psel,      // APB select
  input  wire logic        i_penable,   // APB enable
  input  wire logic        i_pwrite,    // APB direction
  input  wire logic [7:0]  i_paddr,     // APB byte address
  input  wire logic [31:0] i_pwdata,    // APB write data
  output logic      [31:0] o_prdata,    // APB read data
  output logic             o_pready,    // APB ready
  output logic             o_pslverr,   // APB error
  input  wire logic [3:0]  i_al_state,  // Current AL state
  input  wire logic        i_nvm_err,   // Control data corrupt pulse
  input  wire logic [31:0] i_id_word,   // Stored identity word
  input  wire logic        i_pd_frame,  // Cyclic frame arrived pulse
  input  wire logic        i_sync0,     // SYNC0 event pulse
  output logic      [15:0] o_al_code,   // Reported status code
  output logic             o_al_err     // Error pending
);
  import asr_pkg::*;

  // Parameter checks
  if (SYNC_TO_US < 2 || SYNC_TO_US > 65535) begin : g_chk_sync
    $error("SYNC_TO_US out of range");
  end
  if (MBX_MIN_LEN < 1 || MBX_MIN_LEN > 65535) begin : g_chk_mbx
    $error("MBX_MIN_LEN out of range");
  end

  localparam logic [15:0] SYNC_LIM = 16'(SYNC_TO_US);   // Sync limit
  localparam logic [15:0] MBX_MIN  = 16'(MBX_MIN_LEN);  // Mailbox floor
  localparam logic [6:0]  TICK_END = 7'(ASR_TICK_CYC - 1);

  // Bus state
  logic              pready_q;     // Ready flop
  logic              pslverr_q;    // Error flop
  logic       [31:0] prdata_q;     // Read data flop
  logic              done;         // Transfer completes this edge
  logic              wr_done;      // Write completes this edge
  // Stored settings
  logic       [15:0] mbx_q;        // Mailbox length
  logic       [17:0] rxsm_q;       // Receive channel setting
  logic       [17:0] txsm_q;       // Transmit channel setting
  logic       [4:0]  sync_q;       // Event and clock mode
  logic       [15:0] wdt_q;        // Watchdog time
  logic       [31:0] txmap_q;      // Last good transmit entry
  logic       [31:0] rxmap_q;      // Last good receive entry
  // Report state
  logic              err_q;        // Error pending
  logic       [15:0] code_q;       // Held code
  logic       [15:0] hcnt_q;       // Saved event count
  logic       [15:0] hlast_q;      // Last saved code
  logic              boot_q;       // First cycle after reset
  // Timers
  logic       [6:0]  div_q;        // Tick divider
  logic              tick_q;       // One us enable
  logic       [15:0] wdt_cnt_q;    // Watchdog count
  logic       [15:0] sync_cnt_q;   // SYNC0 silence count
  logic              seen_q;       // SYNC0 seen since entry
  // Event decode
  logic [ASR_NE-1:0] evt_v;        // Faults this cycle
  logic              pick_any;     // Some fault now
  logic       [15:0] pick_code;    // Winning code
  logic              ack;          // State request write
  logic       [3:0]  req;          // Requested state
  logic              wdt_act;      // Watchdog armed
  logic              wdt_fire;     // Watchdog expired
  logic              dc_act;       // Clock sync active
  logic              sync_fire;    // SYNC0 silence limit hit
  logic              hist_evt;     // Event to save

  // Known state value
  function automatic logic state_known(input logic [3:0] s);
    return s == ASR_ST_INIT || s == ASR_ST_PREOP || s == ASR_ST_BOOT ||
           s == ASR_ST_SAFEOP || s == ASR_ST_OP;
  endfunction

  // Permitted transition
  function automatic logic state_ok(input logic [3:0] cur, input logic [3:0] nxt);
    logic ok;
    ok = (cur == nxt) || (nxt == ASR_ST_INIT);
    case (cur)
      ASR_ST_INIT:   ok = ok || nxt == ASR_ST_PREOP;
      ASR_ST_PREOP:  ok = ok || nxt == ASR_ST_SAFEOP;
      ASR_ST_SAFEOP: ok = ok || nxt == ASR_ST_PREOP || nxt == ASR_ST_OP;
      ASR_ST_OP:     ok = ok || nxt == ASR_ST_PREOP || nxt == ASR_ST_SAFEOP;
      default:       ok = ok;
    endcase
    return ok;
  endfunction

  // Mapping entry outside served range
  function automatic logic map_bad(input logic [31:0] e, input logic [15:0] lo, input logic [15:0] hi);
    return e[15:0] < lo || e[15:0] > hi || e[23:16] > ASR_SUB_MAX ||
           e[31:24] == 8'h00 || e[31:24] > ASR_SIZE_MAX;
  endfunction

  // Write hit at one offset
  function automatic logic wr_at(input logic w, input logic [7:0] a, input logic [7:0] off);
    return w && a == off;
  endfunction

  // Transfer done at the edge the master samples ready
  assign done    = i_psel && i_penable && pready_q;
  assign wr_done = done && i_pwrite;
  assign ack     = wr_at(wr_done, i_paddr, ASR_OFF_STATE);
  assign req     = i_pwdata[3:0];

  // Ready one cycle after access starts, with data in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= i_psel && i_penable && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (i_psel && i_penable && !pready_q) begin
        case (i_paddr)
          ASR_OFF_STATUS: prdata_q <= {15'h0000, err_q, code_q};
          ASR_OFF_STATE:  prdata_q <= {28'h000_0000, i_al_state};
          ASR_OFF_MBX:    prdata_q <= {16'h0000, mbx_q};
          ASR_OFF_RXSM:   prdata_q <= {14'h0000, rxsm_q};
          ASR_OFF_TXSM:   prdata_q <= {14'h0000, txsm_q};
          ASR_OFF_SYNC:   prdata_q <= {27'h000_0000, sync_q};
          ASR_OFF_WDT:    prdata_q <= {16'h0000, wdt_q};
          ASR_OFF_TXMAP:  prdata_q <= txmap_q;
          ASR_OFF_RXMAP:  prdata_q <= rxmap_q;
          ASR_OFF_CTRL:   prdata_q <= 32'h0000_0000;
          ASR_OFF_HIST:   prdata_q <= {hcnt_q, hlast_q};
          // Unmapped address answers with error
          default:        pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // Setting registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mbx_q   <= ASR_MBX_RST;
      rxsm_q  <= 18'h0_0000;
      txsm_q  <= 18'h0_0000;
      sync_q  <= 5'h00;
      wdt_q   <= ASR_WDT_RST;
      txmap_q <= 32'h0000_0000;
      rxmap_q <= 32'h0000_0000;
    end else begin
      if (wr_at(wr_done, i_paddr, ASR_OFF_MBX)) begin
        mbx_q <= i_pwdata[ASR_LEN_HI:0];
      end
      if (wr_at(wr_done, i_paddr, ASR_OFF_RXSM)) begin
        rxsm_q <= i_pwdata[17:0];
      end
      if (wr_at(wr_done, i_paddr, ASR_OFF_TXSM)) begin
        txsm_q <= i_pwdata[17:0];
      end
      if (wr_at(wr_done, i_paddr, ASR_OFF_SYNC)) begin
        sync_q <= i_pwdata[4:0];
      end
      // Zero watchdog time is refused
      if (evt_v[EV_WDTCFG] == 1'b0 && wr_at(wr_done, i_paddr, ASR_OFF_WDT)) begin  // [R10]
        wdt_q <= i_pwdata[15:0];
      end
      // Only entries in range are kept
      if (wr_at(wr_done, i_paddr, ASR_OFF_TXMAP) && !evt_v[EV_TXMAP]) begin
        txmap_q <= i_pwdata;
      end
      if (wr_at(wr_done, i_paddr, ASR_OFF_RXMAP) && !evt_v[EV_RXMAP]) begin
        rxmap_q <= i_pwdata;
      end
    end
  end

  // Microsecond tick divider
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_q  <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q == TICK_END;
      div_q  <= (div_q == TICK_END) ? 7'h00 : div_q + 7'h01;
    end
  end

  // Process-data watchdog, armed in Operational
  assign wdt_act  = i_al_state == ASR_ST_OP && wdt_q != 16'h0000;
  assign wdt_fire = wdt_act && !i_pd_frame && tick_q && wdt_cnt_q == wdt_q - 16'h0001;  // [R7]
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wdt_cnt_q <= 16'h0000;
    end else if (!wdt_act || i_pd_frame) begin
      wdt_cnt_q <= 16'h0000;
    end else if (tick_q && wdt_cnt_q < wdt_q) begin
      wdt_cnt_q <= wdt_cnt_q + 16'h0001;
    end
  end

  // SYNC0 supervision while clock sync runs
  assign dc_act    = sync_q[4:2] != ASR_DC_OFF &&
                     (i_al_state == ASR_ST_SAFEOP || i_al_state == ASR_ST_OP);
  assign sync_fire = dc_act && !i_sync0 && tick_q && sync_cnt_q == SYNC_LIM - 16'h0001;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_cnt_q <= 16'h0000;
      seen_q     <= 1'b0;
    end else if (!dc_act) begin
      sync_cnt_q <= 16'h0000;
      seen_q     <= 1'b0;
    end else if (i_sync0) begin
      sync_cnt_q <= 16'h0000;
      seen_q     <= 1'b1;
    end else if (tick_q && sync_cnt_q < SYNC_LIM) begin
      sync_cnt_q <= sync_cnt_q + 16'h0001;
    end
  end

  // Identity check in the first cycle after reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // Fault detection
  always_comb begin
    evt_v = '0;
    // State request checks, bootstrap first
    if (ack) begin
      if (req == ASR_ST_BOOT) begin
        evt_v[EV_BOOT] = 1'b1;  // [R4]
      end else if (!state_known(req)) begin
        evt_v[EV_UNKNOWN] = 1'b1;  // [R3]
      end else if (!state_ok(i_al_state, req)) begin
        evt_v[EV_ILLEGAL] = 1'b1;  // [R2]
      end
    end
    evt_v[EV_NVM]    = i_nvm_err;  // [R1]
    evt_v[EV_ID]     = boot_q && i_id_word != ID_EXPECTED;  // [R5]
    evt_v[EV_MBX]    = wr_at(wr_done, i_paddr, ASR_OFF_MBX) && i_pwdata[ASR_LEN_HI:0] < MBX_MIN;  // [R6]
    evt_v[EV_WDT]    = wdt_fire;  // [R7]
    evt_v[EV_RXSM]   = wr_at(wr_done, i_paddr, ASR_OFF_RXSM) && i_pwdata[ASR_LEN_HI:0] == 16'h0000;  // [R8]
    evt_v[EV_TXSM]   = wr_at(wr_done, i_paddr, ASR_OFF_TXSM) && i_pwdata[ASR_LEN_HI:0] == 16'h0000;  // [R9]
    evt_v[EV_WDTCFG] = wr_at(wr_done, i_paddr, ASR_OFF_WDT) && i_pwdata[15:0] == 16'h0000;  // [R10]
    evt_v[EV_INIT]   = wr_at(wr_done, i_paddr, ASR_OFF_CTRL) && i_pwdata[0];  // [R11]
    evt_v[EV_TXMAP]  = wr_at(wr_done, i_paddr, ASR_OFF_TXMAP) &&
                       map_bad(i_pwdata, ASR_TX_IDX_LO, ASR_TX_IDX_HI);  // [R12]
    evt_v[EV_RXMAP]  = wr_at(wr_done, i_paddr, ASR_OFF_RXMAP) &&
                       map_bad(i_pwdata, ASR_RX_IDX_LO, ASR_RX_IDX_HI);  // [R13]
    evt_v[EV_EVMODE] = wr_at(wr_done, i_paddr, ASR_OFF_SYNC) && i_pwdata[1:0] > ASR_EVM_MAX;  // [R14]
    evt_v[EV_BUF]    = (wr_at(wr_done, i_paddr, ASR_OFF_RXSM) || wr_at(wr_done, i_paddr, ASR_OFF_TXSM)) &&
                       i_pwdata[ASR_BUF_LO+1:ASR_BUF_LO] != ASR_BUF_TRIPLE;  // [R15]
    evt_v[EV_SYNCLOST] = sync_fire && seen_q && i_al_state == ASR_ST_OP;  // [R16]
    evt_v[EV_NOSYNC] = sync_fire && !seen_q;  // [R17]
    evt_v[EV_DCCFG]  = wr_at(wr_done, i_paddr, ASR_OFF_SYNC) && i_pwdata[4:2] > ASR_DC_MAX;  // [R18]
  end

  // Lowest slot wins among simultaneous faults
  always_comb begin
    pick_any  = 1'b0;
    pick_code = 16'h0000;
    for (int i = ASR_NE - 1; i >= 0; i--) begin
      if (evt_v[i]) begin
        pick_any  = 1'b1;
        pick_code = ASR_CODE[i];
      end
    end
  end

  // Held code; a state request clears, a new fault wins over it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      err_q  <= 1'b0;
      code_q <= 16'h0000;
    end else if (pick_any && (!err_q || ack)) begin
      err_q  <= 1'b1;  // [R20]
      code_q <= pick_code;
    end else if (ack) begin
      err_q  <= 1'b0;  // [R19]
      code_q <= 16'h0000;
    end
  end

  // Diagnosis history of saved faults
  assign hist_evt = evt_v[EV_NVM] || evt_v[EV_ID];
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hcnt_q  <= 16'h0000;
      hlast_q <= 16'h0000;
    end else if (hist_evt) begin
      hcnt_q  <= (hcnt_q == 16'hFFFF) ? hcnt_q : hcnt_q + 16'h0001;  // [R1] [R5]
      hlast_q <= evt_v[EV_NVM] ? ASR_CODE[EV_NVM] : ASR_CODE[EV_ID];
    end
  end

  // Outputs from flops
  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_al_code = code_q;
  assign o_al_err  = err_q;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_access;
    i_psel && i_penable && !pready_q;
  endsequence
  sequence s_done;
    pready_q ##1 !pready_q;
  endsequence

  apb_ready_a: assert property (s_access |=> s_done)
    else $error("ready did not pulse after access");
  nvm_code_a: assert property (i_nvm_err && !err_q |=> err_q && code_q == 16'h0001)  // [R1]
    else $error("corrupt data code missing");
  nvm_hist_a: assert property (i_nvm_err && hcnt_q != 16'hFFFF |=> hcnt_q == $past(hcnt_q) + 16'h0001)  // [R1]
    else $error("corrupt data not saved");
  illegal_a: assert property (evt_v[EV_ILLEGAL] && !i_nvm_err |=> code_q == 16'h0011)  // [R2]
    else $error("illegal transition code missing");
  nohist_a: assert property (ack && !hist_evt |=> $stable(hcnt_q))  // [R2]
    else $error("state request fault saved");
  boot_a: assert property (ack && req == ASR_ST_BOOT && !i_nvm_err |=> code_q == 16'h0013)  // [R4]
    else $error("bootstrap code missing");
  wdt_keep_a: assert property (evt_v[EV_WDTCFG] |=> $stable(wdt_q))  // [R10]
    else $error("bad watchdog time taken");
  wdt_code_a: assert property (wdt_fire && !err_q && evt_v[5:0] == 6'h00 |=> code_q == 16'h001B)  // [R7]
    else $error("watchdog code missing");
  lost_op_a: assert property (evt_v[EV_SYNCLOST] |-> i_al_state == ASR_ST_OP && seen_q)  // [R16]
    else $error("sync lost outside operational");
  hold_a: assert property (err_q && !ack |=> err_q && $stable(code_q))  // [R19] [R20]
    else $error("held code changed without request");
  clear_a: assert property (ack && !pick_any |=> !err_q && code_q == 16'h0000)  // [R19]
    else $error("state request did not clear");

endmodule

// ---- tb/asr_master_model.sv ----
// Far-side model: cyclic frame and SYNC0 pulse source
`timescale 1ns/100ps
module asr_master_model #(
  parameter int PERIOD = 40  // Cycles between pulses
) (
  input  wire logic i_clk,       // System clock
  input  wire logic i_rst,       // Synchronous reset
  input  wire logic i_frame_en,  // Send cyclic frames
  input  wire logic i_sync_en,   // Send SYNC0 events
  output logic      o_pd_frame,  // Frame pulse
  output logic      o_sync0      // SYNC0 pulse
);
  logic [7:0] cnt_q;  // Cycle counter

  // Free counter spacing the pulses
  always_ff @(posedge i_clk) begin
    cnt_q <= (i_rst || cnt_q >= 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
  end

  // One-cycle pulses, off halves apart so they never coincide
  always_ff @(posedge i_clk) begin
    o_pd_frame <= !i_rst && i_frame_en && cnt_q == 8'h00;
    o_sync0    <= !i_rst && i_sync_en && cnt_q == 8'(PERIOD / 2);
  end
endmodule

// ---- tb/asr_al_status_test.sv ----
// Self-checking bench of the AL status reporter
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module asr_al_status_test;
  import asr_pkg::*;
  localparam logic [31:0] ID_OK = 32'h1234_5678;  // Arbitrary identity value
  localparam logic [7:0]  CA [10] = '{ASR_OFF_MBX, ASR_OFF_RXSM, ASR_OFF_TXSM, ASR_OFF_WDT, ASR_OFF_CTRL,
    ASR_OFF_TXMAP, ASR_OFF_RXMAP, ASR_OFF_SYNC, ASR_OFF_RXSM, ASR_OFF_SYNC};
  localparam logic [31:0] CD [10] = '{32'h0000_0004, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0001, 32'h0101_7000, 32'h0101_6000, 32'h0000_0003, 32'h0001_0004, 32'h0000_0008};
  localparam logic [15:0] CC [10] = '{16'h0016, 16'h001D, 16'h001E, 16'h001F, 16'h0021,
    16'h0024, 16'h0025, 16'h0028, 16'h0029, 16'h0030};
  localparam logic [3:0]  STS [4] = '{ASR_ST_INIT, ASR_ST_PREOP, ASR_ST_SAFEOP, ASR_ST_OP};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, id_word = ID_OK, rnd = 32'h0000_905f, rd;
  logic pready, pslverr, nvm_err = 1'b0, pd_frame, sync0, al_err, frame_en = 1'b0, sync_en = 1'b0, er;
  logic [3:0]  al_state = ASR_ST_INIT;
  logic [15:0] al_code;
  int num_errors = 0, cmp_count = 0;

  always #5 clk = ~clk;

  asr_al_status #(.SYNC_TO_US(3), .MBX_MIN_LEN(8), .ID_EXPECTED(ID_OK)) u_dut (
    .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_al_state(al_state),
    .i_nvm_err(nvm_err), .i_id_word(id_word), .i_pd_frame(pd_frame), .i_sync0(sync0),
    .o_al_code(al_code), .o_al_err(al_err));

  asr_master_model #(.PERIOD(40)) u_far (
    .i_clk(clk), .i_rst(rst), .i_frame_en(frame_en), .i_sync_en(sync_en),
    .o_pd_frame(pd_frame), .o_sync0(sync0));

  // Next pseudo-random word
  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Code expected from a state request
  function automatic logic [15:0] exp_state(logic [3:0] c, logic [3:0] r);
    if (r == ASR_ST_BOOT) return 16'h0013;
    if (!(r inside {ASR_ST_INIT, ASR_ST_PREOP, ASR_ST_SAFEOP, ASR_ST_OP})) return 16'h0012;
    if (r == c || r == ASR_ST_INIT || (c == ASR_ST_INIT && r == ASR_ST_PREOP)
        || (c == ASR_ST_PREOP && r == ASR_ST_SAFEOP) || (c == ASR_ST_SAFEOP && r inside {ASR_ST_PREOP, ASR_ST_OP})
        || (c == ASR_ST_OP && r inside {ASR_ST_PREOP, ASR_ST_SAFEOP})) return 16'h0000;
    return 16'h0011;
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin num_errors++; final_report(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Write, let the code settle, compare code and flag
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [15:0] c);
    apb(1'b1, a, d);
    repeat (2) @(posedge clk);
    `CHK(al_code, c)
    `CHK(al_err, c != 16'h0000)
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, d)
    `CHK(er, e)
  endtask

  // Wait for a pending error with a bound, then compare the code
  task automatic wait_code(input int lim, input logic [15:0] c);
    int n;
    for (n = 0; n < lim && al_err !== 1'b1; n++) @(posedge clk);
    if (n >= lim) begin num_errors++; final_report(); end
    `CHK(al_code, c)
  endtask

  task automatic reset_dut();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    reset_dut();
    `CHK(al_code, 16'h0000)
    rd_chk(ASR_OFF_WDT, {16'h0000, ASR_WDT_RST}, 1'b0);
    rd_chk(ASR_OFF_MBX, {16'h0000, ASR_MBX_RST}, 1'b0);
    rd_chk(8'h30, 32'h0000_0000, 1'b1);
    $display("test regs done");
    // Corner requests, then random ones; each request also acknowledges
    for (int i = 0; i < 28; i++) begin
      rnd = xs(rnd);
      al_state <= (i < 4) ? ASR_ST_INIT : STS[rnd[5:4]];
      @(posedge clk);
      wr_chk(ASR_OFF_STATE, {28'h0, (i < 4) ? 4'(16'h8532 >> (4 * i)) : rnd[3:0]},
             exp_state(al_state, (i < 4) ? 4'(16'h8532 >> (4 * i)) : rnd[3:0]));
    end
    al_state <= ASR_ST_INIT;
    wr_chk(ASR_OFF_STATE, 32'h0000_0008, 16'h0011);
    wr_chk(ASR_OFF_CTRL, 32'h0000_0001, 16'h0011);
    rd_chk(ASR_OFF_STATUS, 32'h0001_0011, 1'b0);
    $display("test state done");
    for (int i = 0; i < 10; i++) begin
      wr_chk(ASR_OFF_STATE, 32'h0000_0001, 16'h0000);
      wr_chk(CA[i], CD[i], CC[i]);
    end
    wr_chk(ASR_OFF_STATE, 32'h0000_0001, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      rnd = xs(rnd);
      wr_chk(ASR_OFF_MBX, {16'h0, 16'h0008 + {4'h0, rnd[11:0]}}, 16'h0000);
      wr_chk(ASR_OFF_TXMAP, {2'b00, rnd[29:24] | 6'd1, 2'b00, rnd[21:16], 4'h6, rnd[11:0]}, 16'h0000);
      wr_chk(ASR_OFF_RXSM, {16'h0000, 4'h0, rnd[11:0] | 12'h001}, 16'h0000);
    end
    wr_chk(ASR_OFF_SYNC, 32'h0000_0000, 16'h0000);
    wr_chk(ASR_OFF_WDT, 32'h0000_0002, 16'h0000);
    $display("test config done");
    frame_en <= 1'b1;
    al_state <= ASR_ST_OP;
    repeat (400) @(posedge clk);
    `CHK(al_err, 1'b0)
    frame_en <= 1'b0;
    wait_code(400, 16'h001B);
    frame_en <= 1'b1;
    wr_chk(ASR_OFF_STATE, 32'h0000_0008, 16'h0000);
    apb(1'b1, ASR_OFF_SYNC, 32'h0000_0004);
    wait_code(500, 16'h002D);
    sync_en <= 1'b1;
    wr_chk(ASR_OFF_STATE, 32'h0000_0008, 16'h0000);
    repeat (500) @(posedge clk);
    `CHK(al_err, 1'b0)
    sync_en <= 1'b0;
    wait_code(500, 16'h002C);
    $display("test timing done");
    al_state <= ASR_ST_INIT;
    frame_en <= 1'b0;
    wr_chk(ASR_OFF_STATE, 32'h0000_0001, 16'h0000);
    wr_chk(ASR_OFF_SYNC, 32'h0000_0000, 16'h0000);
    nvm_err <= 1'b1;
    @(posedge clk);
    nvm_err <= 1'b0;
    wait_code(10, 16'h0001);
    rd_chk(ASR_OFF_HIST, 32'h0001_0001, 1'b0);
    id_word <= ~ID_OK;
    reset_dut();
    wait_code(10, 16'h0014);
    apb(1'b0, ASR_OFF_HIST, 32'h0000_0000);
    `CHK(rd[15:0], 16'h0014)
    $display("test memory done");
    final_report();
  end
endmodule
